//--- rtl/cce_consts.vh
// Constants for the call and clear instruction executor
`ifndef CCE_CONSTS_VH
`define CCE_CONSTS_VH
`define CCE_CALL_OP 4'h9
`define CCE_ZFILE_TOP 7'h03
`define CCE_ZACC_WORD 12'h040
`define CCE_KICK_WORD 12'h004
`define CCE_PAGE_LO 5
`define CCE_PAGE_HI 6
`define CCE_EXPIRY_BIT 4
`define CCE_SLEEP_BIT 3
`define CCE_Z_BIT 2
`define CCE_STATUS_RST 8'h18
`define CCE_PC_RST 11'h7FF
`define CCE_CALL_CYCLES 2'h2
`define CCE_A_CTRL 32'h00000000
`define CCE_A_STAT 32'h00000004
`define CCE_A_PCNT 32'h00000008
`define CCE_A_WREG 32'h0000000C
`define CCE_A_WDOG 32'h00000010
`define CCE_A_TOS 32'h00000014
`define CCE_A_FILE 32'h00000080
`define CCE_RESP_OK 2'h0
`define CCE_RESP_ERR 2'h2
`endif

//--- rtl/cce_exec.v
// Call and clear instruction executor with AXI4-Lite register access
`timescale 1ns/100ps
`include "cce_consts.vh"
module cce_exec #(
	parameter PC_W = 11,
	parameter NREGS = 32
) (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [11:0] instr_word,
	input wire instr_valid,
	output wire instr_ready,
	input wire prescaler_to_watchdog,
	output reg prescaler_clear,
	output reg [PC_W-1:0] program_counter,
	output reg busy
);
	reg [7:0] status;
	reg [7:0] wreg;
	reg [7:0] watchdog;
	reg [PC_W-1:0] stack0;
	reg [PC_W-1:0] stack1;
	reg [7:0] file_mem [0:NREGS-1];
	reg [31:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg aw_held;
	reg w_held;
	reg step;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	integer i;
	wire is_call = instr_word[11:8] == `CCE_CALL_OP;
	wire is_zfile = instr_word[11:5] == `CCE_ZFILE_TOP;
	wire is_zacc = instr_word == `CCE_ZACC_WORD;
	wire is_kick = instr_word == `CCE_KICK_WORD;
	wire go = instr_valid && !busy;
	wire do_wr = aw_held && w_held && !s_axi_bvalid;
	assign instr_ready = !busy;
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	function in_file;
		input [31:0] a;
		begin
			in_file = a >= `CCE_A_FILE && a < `CCE_A_FILE + 4 * NREGS;
		end
	endfunction

	function [4:0] file_idx;
		input [31:0] a;
		begin
			file_idx = a[6:2];
		end
	endfunction

	wire bus_ok = do_wr && w_strb[0] && !go;
	wire wr_stat = bus_ok && aw_addr == `CCE_A_STAT;
	wire wr_acc = bus_ok && aw_addr == `CCE_A_WREG;
	wire wr_file = bus_ok && in_file(aw_addr);
	wire wr_map = aw_addr == `CCE_A_CTRL || aw_addr == `CCE_A_STAT ||
		aw_addr == `CCE_A_WREG || in_file(aw_addr);

	// Read data selection
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `CCE_RESP_OK;
		case (s_axi_araddr)
			`CCE_A_CTRL:
				next_rdata = {31'h00000000, step};
			`CCE_A_STAT:
				next_rdata = {24'h000000, status};
			`CCE_A_PCNT:
				next_rdata = {{(32-PC_W){1'b0}}, program_counter};
			`CCE_A_WREG:
				next_rdata = {24'h000000, wreg};
			`CCE_A_WDOG:
				next_rdata = {24'h000000, watchdog};
			`CCE_A_TOS:
				next_rdata = {{(32-PC_W){1'b0}}, stack0};
			default: begin
				if (in_file(s_axi_araddr))
					next_rdata = {24'h000000,
						file_mem[file_idx(s_axi_araddr)]};
				else
					next_rresp = `CCE_RESP_ERR;
			end
		endcase
	end

	// Write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CCE_RESP_OK;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_map)
					s_axi_bresp <= `CCE_RESP_OK;
				else
					s_axi_bresp <= `CCE_RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `CCE_RESP_OK;
			s_axi_rdata <= 32'h00000000;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			program_counter <= `CCE_PC_RST;
			status <= `CCE_STATUS_RST;
			wreg <= 8'h00;
			watchdog <= 8'h00;
			stack0 <= {PC_W{1'b0}};
			stack1 <= {PC_W{1'b0}};
			busy <= 1'b0;
			step <= 1'b0;
			prescaler_clear <= 1'b0;
			for (i = 0; i < NREGS; i = i + 1) begin
				file_mem[i] <= 8'h00;
			end
		end else begin
			prescaler_clear <= 1'b0;
			if (!busy)
				watchdog <= watchdog + 8'h01;
			if (busy) begin
				// Second cycle of a call
				busy <= 1'b0;
				step <= 1'b0;
			end else if (go) begin
				if (is_call) begin
					stack1 <= stack0;
					stack0 <= program_counter + 1'b1;
					program_counter <= {status[`CCE_PAGE_HI:`CCE_PAGE_LO],
						1'b0,
						instr_word[7:0]};
					busy <= 1'b1;
					step <= 1'b1;
				end else begin
					program_counter <= program_counter + 1'b1;
					if (is_zfile) begin
						file_mem[instr_word[4:0]] <= 8'h00;
						status[`CCE_Z_BIT] <= 1'b1;
					end else if (is_zacc) begin
						wreg <= 8'h00;
						status[`CCE_Z_BIT] <= 1'b1;
					end else if (is_kick) begin
						watchdog <= 8'h00;
						prescaler_clear <= prescaler_to_watchdog;
						status[`CCE_EXPIRY_BIT] <= 1'b1;
						status[`CCE_SLEEP_BIT] <= 1'b1;
					end
				end
			end
			// Register writes from the bus
			if (wr_stat)
				status <= w_data[7:0];
			if (wr_acc)
				wreg <= w_data[7:0];
			if (wr_file)
				file_mem[file_idx(aw_addr)] <= w_data[7:0];
		end
	end
endmodule // cce_exec

//--- tb/cce_exec_asserts.sv
// Port checker for the call and clear executor
`timescale 1ns/100ps
module cce_chk #(parameter PC_W = 11) (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] instr_word,
	input wire instr_valid,
	input wire instr_ready,
	input wire prescaler_to_watchdog,
	input wire prescaler_clear,
	input wire [PC_W-1:0] program_counter,
	input wire busy
);
	wire tk = instr_valid && instr_ready;
	wire kick = tk && instr_word == 12'h004;
	wire call = tk && instr_word[11:8] == 4'h9;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence call_take;
		call;
	endsequence
	sequence two_cycles;
		busy ##1 !busy;
	endsequence
	a_call_busy: assert property (call_take |=> two_cycles)
		else $error("call length");
	a_call_low: assert property (call_take |=>
		program_counter[7:0] == $past(instr_word[7:0]))
		else $error("call target");
	a_call_bit8: assert property (call_take |=> !program_counter[8])
		else $error("call bit 8");
	a_busy_hold: assert property (busy |=> $stable(program_counter))
		else $error("counter moved");
	a_clear_step: assert property (tk && !call |=>
		program_counter == $past(program_counter) + 1'b1)
		else $error("counter step");
	a_kick_pre: assert property (kick |=>
		prescaler_clear == $past(prescaler_to_watchdog))
		else $error("prescaler clear");
	a_pre_cause: assert property (prescaler_clear |-> $past(kick))
		else $error("stray clear");
	a_busy_cause: assert property ($rose(busy) |-> $past(call))
		else $error("stray busy");
endmodule // cce_chk
bind cce_exec cce_chk #(.PC_W(PC_W)) cce_chk_inst (.aclk(aclk),
	.aresetn(aresetn), .instr_word(instr_word), .instr_valid(instr_valid),
	.instr_ready(instr_ready), .prescaler_to_watchdog(prescaler_to_watchdog),
	.prescaler_clear(prescaler_clear), .program_counter(program_counter),
	.busy(busy));

//--- tb/tb_top.sv
// Testbench for the call and clear executor
`timescale 1ns/100ps
module tb_top;
	reg aclk = 0, aresetn = 0, av = 0, wv = 0, br = 0, arv = 0, rr = 0;
	reg iv = 0, pw = 1;
	reg [31:0] aa = 0, wd = 0, ra = 0, d;
	reg [11:0] iw = 0;
	reg [1:0] r;
	wire awr, wr, bv, arr, rv, ir, pcl, bs;
	wire [1:0] bre, rre;
	wire [31:0] rd;
	wire [10:0] pcv;
	integer miscompares = 0, compares = 0;
	cce_exec cce_exec_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .instr_word(iw),
		.instr_valid(iv), .instr_ready(ir), .prescaler_to_watchdog(pw),
		.prescaler_clear(pcl), .program_counter(pcv), .busy(bs));
	initial begin
		forever #5 aclk = ~aclk;
	end
	task chk(input [31:0] g, e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("BAD %0t %h %h", $time, g, e);
			end
		end
	endtask
	task wrt(input [31:0] a, v);
		reg ad, dd;
		begin
			ad = 1'b0;
			dd = 1'b0;
			aa <= a;
			wd <= v;
			av <= 1;
			wv <= 1;
			br <= 1;
			while (!(ad && dd)) begin
				@(posedge aclk);
				if (!ad && awr) begin
					ad = 1'b1;
					av <= 0;
				end
				if (!dd && wr) begin
					dd = 1'b1;
					wv <= 0;
				end
			end
			while (!bv) @(posedge aclk);
			r = bre;
			br <= 0;
			@(posedge aclk);
		end
	endtask
	task rdr(input [31:0] a);
		begin
			ra <= a;
			arv <= 1;
			rr <= 1;
			do @(posedge aclk); while (!arr);
			arv <= 0;
			while (!rv) @(posedge aclk);
			d = rd;
			r = rre;
			rr <= 0;
			@(posedge aclk);
		end
	endtask
	task ins(input [11:0] w);
		begin
			iw <= w;
			iv <= 1;
			do @(posedge aclk); while (!ir);
			iv <= 0;
			@(posedge aclk);
		end
	endtask
	task t_clear;
		begin
			wrt(32'h8C, 32'h5A);
			chk(r, 2'h0);
			wrt(32'h88, 32'h5A);
			wrt(32'h0C, 32'h5A);
			wrt(32'h04, 32'h20);
			ins(12'h063);
			chk(pcv, 11'h000);
			rdr(32'h8C);
			chk(d, 32'h0);
			rdr(32'h88);
			chk(d, 32'h5A);
			rdr(32'h04);
			chk(d & 32'h64, 32'h24);
			wrt(32'h04, 32'h20);
			ins(12'h040);
			chk(pcv, 11'h001);
			rdr(32'h0C);
			chk(d, 32'h0);
			rdr(32'h04);
			chk(d & 32'h64, 32'h24);
		end
	endtask
	task t_kick;
		begin
			pw <= 0;
			ins(12'h004);
			chk(pcl, 1'b0);
			pw <= 1;
			ins(12'h004);
			chk(pcl, 1'b1);
			chk(pcv, 11'h003);
			rdr(32'h10);
			chk(d, 32'h1);
			rdr(32'h04);
			chk(d & 32'h7C, 32'h3C);
		end
	endtask
	task t_call;
		begin
			ins(12'h9AB);
			chk(pcv, 11'h2AB);
			rdr(32'h14);
			chk(d, 32'h4);
			rdr(32'h04);
			chk(d & 32'h7C, 32'h3C);
			rdr(32'h40);
			chk(r, 2'h2);
		end
	endtask
	task results;
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial begin
		#20000;
		miscompares = miscompares + 1;
		results;
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		t_clear;
		t_kick;
		t_call;
		results;
	end
endmodule // tb_top
